/* File: src/arfr_pkg.sv */
// Shared constants for the converter result and filter register block.
// Assumes one 50 MHz system clock and a four-wire serial host port.
package arfr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ARFR_ADDR_RESULT = 4'h4;
  localparam logic [3:0] ARFR_ADDR_FILTER = 4'h5;
  localparam logic [23:0] ARFR_RESULT_RST = 24'h00_0000;
  localparam logic [15:0] ARFR_FILTER_RST = 16'h0500;
  localparam logic [15:0] ARFR_FILTER_WMASK = 16'h0F7F;
  // ----------------------------------------
  // Filter field positions
  // ----------------------------------------
  localparam int ARFR_REJ_EN_BIT = 11;
  localparam int ARFR_REJ_SEL_LSB = 8;
  localparam int ARFR_ORDER_LSB = 5;
  localparam int ARFR_RATE_LSB = 0;
  localparam logic [4:0] ARFR_RATE_MAX = 5'h06;
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam logic [5:0] ARFR_CMD_BITS = 6'h08;
  localparam logic [5:0] ARFR_LEN_FULL = 6'h18;
  localparam logic [5:0] ARFR_LEN_SHORT = 6'h10;
  localparam logic [5:0] ARFR_LEN_STAT = 6'h08;
  localparam logic [5:0] ARFR_LEN_REG = 6'h10;
  localparam int ARFR_CMD_READ_BIT = 6;
  localparam int ARFR_CMD_NWEN_BIT = 7;
  localparam int ARFR_CHANNELS = 4;
  // ----------------------------------------
  // Serial port states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ARFR_IDLE = 2'b00,
    ARFR_CMD = 2'b01,
    ARFR_RDATA = 2'b11,
    ARFR_WDATA = 2'b10
  } arfr_state_t;
endpackage : arfr_pkg

/* File: src/arfr_sync.sv */
// Two-stage synchroniser for levels from outside the clock domain.
// Assumes the consumer reads only sync_o.
`timescale 1ns/10ps
module arfr_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : arfr_sync

/* File: src/arfr_top.sv */
// Result register and shared filter setup behind a four-wire serial port.
// Assumes host pins arrive asynchronously; converter side is on clk_i.
// How it works
// RULE_01 - Result read drives ready flag and pin high
// RULE_02 - Repeated reads return same stored result
// RULE_03 - No result update while result read runs
// RULE_04 - Host cannot predict next result from ready
// RULE_05 - Status append makes thirty-two bit read
// RULE_06 - Short option rounds result to sixteen bits
// RULE_07 - Filter write aborts and restarts conversion sequence
// RULE_08 - Filter write copies to every enabled channel
// RULE_09 - Bit eleven enables line rejection, reset zero
// RULE_10 - Rejection mode codes two to six valid
// RULE_11 - Order codes zero and three valid only
// RULE_12 - Output rate codes zero through six
// RULE_14 - Short plus status gives twenty-four bit read
// RULE_13 - No channel enabled means channel zero enabled
`timescale 1ns/10ps
module arfr_top
  import arfr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_rdy_n_o,
  output logic dout_oe_o,
  input wire logic [3:0] chan_enable_i,
  input wire logic status_append_i,
  input wire logic short_word_select_i,
  input wire logic result_valid_i,
  input wire logic [23:0] result_data_i,
  input wire logic [7:0] status_i,
  output logic ready_n_o,
  output logic conv_restart_o,
  output logic [63:0] filter_setup_o,
  output logic [3:0] filter_legal_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] arfr_round16(input logic [23:0] value);
    logic [16:0] sum;
    sum = {1'b0, value[23:8]} + {16'h0000, value[7]};
    arfr_round16 = sum[16] ? 16'hFFFF : sum[15:0]; // see RULE_06
  endfunction : arfr_round16

  function automatic logic arfr_legal(input logic [15:0] cfg);
    logic [2:0] sel;
    logic [1:0] ord;
    logic [4:0] rate;
    sel = cfg[ARFR_REJ_SEL_LSB +: 3];
    ord = cfg[ARFR_ORDER_LSB +: 2];
    rate = cfg[ARFR_RATE_LSB +: 5];
    arfr_legal = (!cfg[ARFR_REJ_EN_BIT] || (sel >= 3'h2 && sel <= 3'h6)) // see RULE_09 see RULE_10
      && (ord == 2'h0 || ord == 2'h3) // see RULE_11
      && (rate <= ARFR_RATE_MAX); // see RULE_12
  endfunction : arfr_legal

  // ----------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------
  logic [2:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic sclk_d_reg;
  logic sclk_rise;
  logic sclk_fall;

  arfr_sync #(.WIDTH(3), .RESET_VAL(3'b110)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({sclk_i, cs_n_i, din_i}),
    .sync_o(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign din_s = pins_sync[0];
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;

  // ----------------------------------------
  // Serial port and register state
  // ----------------------------------------
  arfr_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] len_reg, len_next;
  logic [31:0] tx_reg, tx_next;
  logic [15:0] rx_reg, rx_next;
  logic dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic reading_reg, reading_next;
  logic ready_n_reg, ready_n_next;
  logic [23:0] result_reg, result_next;
  logic pend_reg, pend_next;
  logic [23:0] pend_data_reg, pend_data_next;
  logic restart_reg, restart_next;
  logic [15:0] filt_reg [ARFR_CHANNELS];
  logic [15:0] filt_next [ARFR_CHANNELS];
  logic [3:0] legal_reg, legal_next;
  logic [3:0] chan_eff;
  logic [15:0] read_filt;
  logic [7:0] cmd_byte;
  logic [3:0] cmd_addr;

  assign chan_eff = (chan_enable_i == 4'h0) ? 4'h1 : chan_enable_i; // see RULE_13
  assign cmd_byte = {rx_reg[6:0], din_s};
  assign cmd_addr = cmd_byte[3:0];

  always_comb begin
    read_filt = filt_reg[0];
    for (int i = ARFR_CHANNELS - 1; i >= 0; i--) begin
      if (chan_eff[i]) begin
        read_filt = filt_reg[i];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    dout_next = dout_reg;
    oe_next = !cs_n_s;
    reading_next = reading_reg;
    ready_n_next = ready_n_reg;
    result_next = result_reg;
    pend_next = pend_reg;
    pend_data_next = pend_data_reg;
    restart_next = 1'b0;
    for (int i = 0; i < ARFR_CHANNELS; i++) begin
      filt_next[i] = filt_reg[i];
    end
    for (int i = 0; i < ARFR_CHANNELS; i++) begin
      legal_next[i] = arfr_legal(filt_reg[i]);
    end

    case (state_reg)
      ARFR_IDLE: begin
        if (!cs_n_s) begin
          state_next = ARFR_CMD;
          cnt_next = 6'h00;
        end
      end
      ARFR_CMD: begin
        if (sclk_rise) begin
          rx_next = {rx_reg[14:0], din_s};
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == ARFR_CMD_BITS - 6'h01) begin
            cnt_next = 6'h00;
            if (cmd_byte[ARFR_CMD_NWEN_BIT]) begin
              state_next = ARFR_CMD;
            end else if (cmd_byte[ARFR_CMD_READ_BIT]) begin
              state_next = ARFR_RDATA;
              if (cmd_addr == ARFR_ADDR_RESULT) begin
                reading_next = 1'b1; // see RULE_03
                ready_n_next = 1'b1; // see RULE_01
                if (short_word_select_i) begin
                  tx_next = {arfr_round16(result_reg), status_i, 8'h00}; // see RULE_02 see RULE_14
                  len_next = ARFR_LEN_SHORT + (status_append_i ? ARFR_LEN_STAT : 6'h00); // see RULE_14
                end else begin
                  tx_next = {result_reg, status_i}; // see RULE_05
                  len_next = ARFR_LEN_FULL + (status_append_i ? ARFR_LEN_STAT : 6'h00); // see RULE_05
                end
              end else if (cmd_addr == ARFR_ADDR_FILTER) begin
                tx_next = {read_filt, 16'h0000};
                len_next = ARFR_LEN_REG;
              end else begin
                tx_next = 32'h0000_0000;
                len_next = ARFR_LEN_REG;
              end
            end else begin
              state_next = (cmd_addr == ARFR_ADDR_FILTER) ? ARFR_WDATA : ARFR_CMD;
              len_next = ARFR_LEN_REG;
            end
          end
        end
      end
      ARFR_RDATA: begin
        if (sclk_fall) begin
          dout_next = tx_reg[31];
          tx_next = {tx_reg[30:0], 1'b0};
        end
        if (sclk_rise) begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == len_reg - 6'h01) begin
            state_next = ARFR_CMD;
            cnt_next = 6'h00;
            reading_next = 1'b0;
          end
        end
      end
      ARFR_WDATA: begin
        if (sclk_rise) begin
          rx_next = {rx_reg[14:0], din_s};
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == len_reg - 6'h01) begin
            state_next = ARFR_CMD;
            cnt_next = 6'h00;
            restart_next = 1'b1; // see RULE_07
            for (int i = 0; i < ARFR_CHANNELS; i++) begin
              if (chan_eff[i]) begin
                filt_next[i] = {rx_reg[14:0], din_s} & ARFR_FILTER_WMASK; // see RULE_08
              end
            end
          end
        end
      end
      default: begin
        state_next = ARFR_IDLE;
      end
    endcase

    if (cs_n_s) begin
      state_next = ARFR_IDLE;
      reading_next = 1'b0;
    end

    if (state_next != ARFR_RDATA) begin
      dout_next = ready_n_next;
    end

    // Hold new results back while the result is being shifted out
    if (result_valid_i) begin
      pend_next = 1'b1;
      pend_data_next = result_data_i;
    end
    if (!reading_reg && !reading_next && (pend_reg || result_valid_i)) begin // see RULE_03
      result_next = result_valid_i ? result_data_i : pend_data_reg;
      pend_next = 1'b0;
      ready_n_next = 1'b0;
      if (state_next != ARFR_RDATA) begin
        dout_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_reg <= 1'b1;
      state_reg <= ARFR_IDLE;
      cnt_reg <= 6'h00;
      len_reg <= 6'h00;
      tx_reg <= 32'h0000_0000;
      rx_reg <= 16'h0000;
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
      reading_reg <= 1'b0;
      ready_n_reg <= 1'b1;
      result_reg <= ARFR_RESULT_RST;
      pend_reg <= 1'b0;
      pend_data_reg <= ARFR_RESULT_RST;
      restart_reg <= 1'b0;
      legal_reg <= 4'hF;
      for (int i = 0; i < ARFR_CHANNELS; i++) begin
        filt_reg[i] <= ARFR_FILTER_RST;
      end
    end else begin
      sclk_d_reg <= sclk_s;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      reading_reg <= reading_next;
      ready_n_reg <= ready_n_next;
      result_reg <= result_next;
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      restart_reg <= restart_next;
      legal_reg <= legal_next;
      for (int i = 0; i < ARFR_CHANNELS; i++) begin
        filt_reg[i] <= filt_next[i];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dout_rdy_n_o = dout_reg;
  assign dout_oe_o = oe_reg;
  assign ready_n_o = ready_n_reg;
  assign conv_restart_o = restart_reg;
  assign filter_setup_o = {filt_reg[3], filt_reg[2], filt_reg[1], filt_reg[0]};
  assign filter_legal_o = legal_reg;
endmodule : arfr_top

/* File: bench/arfr_monitor.sv */
// Checker on the ports of arfr_top, attached by bind.
// Assumes the host holds cs low ten clocks around each frame.
`timescale 1ns/10ps
module arfr_monitor import arfr_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dout_rdy_n_o,
  input wire logic dout_oe_o,
  input wire logic result_valid_i,
  input wire logic ready_n_o,
  input wire logic conv_restart_o,
  input wire logic [63:0] filter_setup_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_oe; !cs_n_i [*5] |-> dout_oe_o; endproperty
  property p_pin; (!cs_n_i && sclk_i && $stable(ready_n_o)) [*8] |-> dout_rdy_n_o == ready_n_o; endproperty
  property p_rise; $rose(ready_n_o) |-> !cs_n_i; endproperty
  property p_store; cs_n_i [*5] ##0 result_valid_i |=> !ready_n_o; endproperty
  property p_pulse; conv_restart_o |=> !conv_restart_o; endproperty
  property p_wr; conv_restart_o |-> !$past(cs_n_i, 3); endproperty
  property p_copy;
    $changed(filter_setup_o) |-> conv_restart_o;
  endproperty
  property p_mask; (filter_setup_o & ~{4{ARFR_FILTER_WMASK}}) == 64'h0; endproperty
  a_oe: assert property (p_oe) else $error("dout enable low in frame");
  a_pin: assert property (p_pin) else $error("pin differs from ready flag");
  a_rise: assert property (p_rise) else $error("ready flag set with no frame");
  a_store: assert property (p_store) else $error("result not stored");
  a_pulse: assert property (p_pulse) else $error("restart pulse too long");
  a_wr: assert property (p_wr) else $error("restart with no frame");
  a_copy: assert property (p_copy) else $error("copy changed with no restart");
  a_mask: assert property (p_mask) else $error("reserved filter bits set");
  c_restart: cover property (conv_restart_o);
  c_ready: cover property ($fell(ready_n_o));
  c_frame: cover property (!cs_n_i [*8]);
endmodule : arfr_monitor
bind arfr_top arfr_monitor mon (.clk_i, .rstn_i, .sclk_i, .cs_n_i, .dout_rdy_n_o, .dout_oe_o, .result_valid_i,
  .ready_n_o, .conv_restart_o, .filter_setup_o);

/* File: bench/arfr_host.sv */
// Host model on the four-wire serial port.
// Assumes clk_i is the system clock; one sclk bit is eight clocks.
`timescale 1ns/10ps
module arfr_host (
  input wire logic clk_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  initial {sclk_o, cs_n_o, din_o} = 3'h7;
  // Fixed frame timing, nothing taken from ready
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd << (32 - n)};
    rd = '0;
    cs_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int b = 0; b < 8 + n; b++) begin
      sclk_o <= 1'b0;
      din_o <= sh[39 - b];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd = {rd[30:0], dout_oe_i ? dout_i : 1'bx};
      repeat (2) @(posedge clk_i);
    end
    repeat (10) @(posedge clk_i);
    cs_n_o <= 1'b1;
    din_o <= ~din_o;
    repeat (6) @(posedge clk_i);
  endtask : xfer
endmodule : arfr_host

/* File: bench/testbench.sv */
// Self-checking bench for arfr_top with the serial host model.
// Assumes arfr_host drives the pins; converter side is driven here.
`timescale 1ns/10ps
module testbench import arfr_pkg::*;;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rv = 1'b0, sa = 1'b0, sw = 1'b0;
  logic [3:0] ce = 4'h0;
  logic [23:0] rdat = 24'h00_0000;
  logic [7:0] stat = 8'h00;
  logic sclk, cs_n, din, dout, oe, ready_n, restart;
  logic [63:0] fset, fexp = {4{ARFR_FILTER_RST}};
  logic [3:0] legal;
  logic [31:0] rd;
  int num_errors = 0, n_checks = 0, restarts = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (restart === 1'b1) restarts++;
  arfr_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_rdy_n_o(dout),
    .dout_oe_o(oe), .chan_enable_i(ce), .status_append_i(sa), .short_word_select_i(sw), .result_valid_i(rv),
    .result_data_i(rdat), .status_i(stat), .ready_n_o(ready_n), .conv_restart_o(restart), .filter_setup_o(fset),
    .filter_legal_o(legal));
  arfr_host host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_i(oe));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic push(input logic [23:0] d);
    rdat <= d;
    rv <= 1'b1;
    @(posedge clk_i);
    rv <= 1'b0;
    @(posedge clk_i);
  endtask : push
  task automatic wf(input logic [15:0] v);
    logic [3:0] en;
    logic ok;
    int r0;
    en = (ce == 4'h0) ? 4'h1 : ce;
    ok = (!v[11] || (v[10:8] inside {[3'h2:3'h6]})) && (v[6:5] inside {2'h0, 2'h3}) && (v[4:0] <= 5'h06);
    r0 = restarts;
    host.xfer(8'h05, 16, {16'h0, v}, rd);
    check(64'(restarts - r0), 64'h1);
    for (int c = 0; c < 4; c++) begin
      if (en[c]) fexp[c*16 +: 16] = v & ARFR_FILTER_WMASK;
      if (en[c]) check(legal[c], ok);
    end
    check(fset, fexp);
    host.xfer(8'h45, 16, 32'h0, rd);
    check(rd[15:0], v & ARFR_FILTER_WMASK);
  endtask : wf
  initial begin
    #1000000;
    num_errors++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(fset, fexp);
    push(24'h12_3456);
    host.xfer(8'h44, 24, 32'h0, rd);
    check(ready_n, 1'b1);
    check(rd[23:0], 24'h12_3456);
    push(24'hAB_CDEF);
    fork
      host.xfer(8'h44, 24, 32'h0, rd);
      begin
        repeat (120) @(posedge clk_i);
        push(24'h65_4321);
      end
    join
    check(rd[23:0], 24'hAB_CDEF);
    check(ready_n, 1'b0);
    host.xfer(8'h44, 24, 32'h0, rd);
    check(rd[23:0], 24'h65_4321);
    sa <= 1'b1;
    stat <= 8'hA5;
    push(24'h12_3480);
    host.xfer(8'h44, 32, 32'h0, rd);
    check(rd, 32'h1234_80A5);
    sw <= 1'b1;
    host.xfer(8'h44, 24, 32'h0, rd);
    check(rd[23:0], 24'h12_35A5);
    sa <= 1'b0;
    push(24'hFF_FF90);
    host.xfer(8'h44, 16, 32'h0, rd);
    check(rd[15:0], 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      ce <= 4'(i * 3);
      @(posedge clk_i);
      wf({4'hF, i[0], i[2:0], 1'b1, i[1:0], 5'(i)});
    end
    host.xfer(8'h04, 0, 32'h0, rd);
    check(fset, fexp);
    host.xfer(8'h4F, 16, 32'h0, rd);
    check(rd[15:0], 16'h0000);
    results();
  end
endmodule : testbench
